/* rtl/tlss_pkg.sv */
package tlss_pkg;

  localparam int unsigned TLSS_UNITS = 8;

  // Clock and faceplate indicator timing
  localparam int unsigned TLSS_CLK_HZ = 100_000_000;
  localparam int unsigned TLSS_LED_HALF_MS = 250;
  localparam int unsigned TLSS_LED_HALF_CYC = TLSS_LED_HALF_MS * (TLSS_CLK_HZ / 1000);
  localparam int unsigned TLSS_LED_FLASHES = 3;

  // Software command opcodes
  localparam logic [3:0] TLSS_OP_CONFIG = 4'h1;
  localparam logic [3:0] TLSS_OP_SEIZE = 4'h2;
  localparam logic [3:0] TLSS_OP_ANSWER = 4'h3;
  localparam logic [3:0] TLSS_OP_RELEASE = 4'h4;
  localparam logic [3:0] TLSS_OP_PAD = 4'h5;
  localparam logic [3:0] TLSS_OP_UNIT_DIS = 4'h6;
  localparam logic [3:0] TLSS_OP_UNIT_EN = 4'h7;
  localparam logic [3:0] TLSS_OP_CARD_EN = 4'h8;
  localparam logic [3:0] TLSS_OP_CARD_DIS = 4'h9;

  // Configuration byte field positions
  localparam int unsigned TLSS_CFG_BATT = 0;
  localparam int unsigned TLSS_CFG_BUSY = 1;
  localparam int unsigned TLSS_CFG_REV = 2;
  localparam int unsigned TLSS_CFG_ALAW = 3;
  localparam int unsigned TLSS_CFG_PAD = 0;
  localparam logic [3:0] TLSS_CFG_RESET = 4'h0;

  // Event message codes
  localparam logic [2:0] TLSS_EV_ANSWER_ACK = 3'h1;
  localparam logic [2:0] TLSS_EV_SEIZE_ACK = 3'h2;
  localparam logic [2:0] TLSS_EV_POL_REV = 3'h3;
  localparam logic [2:0] TLSS_EV_DISCONNECT = 3'h4;
  localparam logic [2:0] TLSS_EV_RELEASE_CONF = 3'h5;
  localparam logic [2:0] TLSS_EV_METER = 3'h6;

  typedef enum logic [2:0]
  {
    TLSS_U_IDLE = 3'b000,
    TLSS_U_RINGING = 3'b001,
    TLSS_U_SEIZED = 3'b010,
    TLSS_U_TALK = 3'b011,
    TLSS_U_CLEARED = 3'b100
  } tlss_unit_state_t;

  typedef enum logic [2:0]
  {
    TLSS_L_TEST = 3'b000,
    TLSS_L_FLASH = 3'b001,
    TLSS_L_HOLD = 3'b010,
    TLSS_L_OFF = 3'b011,
    TLSS_L_FAIL = 3'b100
  } tlss_led_state_t;

endpackage

/* rtl/tlss_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module tlss_unit
  import tlss_pkg::*;
#(
  parameter bit METER_EQUIPPED = 1'b1
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic unit_on,
  input wire logic ring_sense,
  input wire logic polarity,
  input wire logic busy_tone,
  input wire logic meter_tone,
  input wire logic cfg_batt_sup,
  input wire logic cfg_busy_det,
  input wire logic cfg_rev_det,
  input wire logic do_seize,
  input wire logic do_answer,
  input wire logic do_release,
  input wire logic ev_ack,
  output logic ring_detector_connect,
  output logic loop_close,
  output logic unit_idle,
  output logic ev_valid,
  output logic [2:0] ev_code
);

  tlss_unit_state_t state_q, state_d;
  logic pol_q, pol_d;
  logic rev_clear_q, rev_clear_d;
  logic meter_prev_q;
  logic ev_valid_q, ev_valid_d;
  logic [2:0] ev_code_q, ev_code_d;
  logic raise;
  logic ring_q, loop_q;

  wire pol_flip = polarity != pol_q;
  wire meter_rise = METER_EQUIPPED && meter_tone && !meter_prev_q;

  // Supervision sequence; unless the unit is off, no move while a message waits to be queued
  always_comb
  begin
    state_d = state_q;
    pol_d = pol_q;
    rev_clear_d = rev_clear_q;
    raise = 1'b0;
    ev_code_d = ev_code_q;
    if (!unit_on)
    begin
      state_d = TLSS_U_IDLE;
      rev_clear_d = 1'b0;
    end
    else if (!ev_valid_q)
    begin
      case (state_q)
        TLSS_U_IDLE:
        begin
          if (do_seize)
          begin
            state_d = TLSS_U_SEIZED;
            pol_d = polarity;
            raise = cfg_batt_sup;
            ev_code_d = TLSS_EV_SEIZE_ACK;
          end
          else if (ring_sense)
            state_d = TLSS_U_RINGING;
        end
        TLSS_U_RINGING:
        begin
          if (do_answer)
          begin
            state_d = TLSS_U_TALK;
            pol_d = polarity;
            raise = cfg_batt_sup;
            ev_code_d = TLSS_EV_ANSWER_ACK;
          end
          else if (do_release)
            state_d = TLSS_U_IDLE;
        end
        TLSS_U_SEIZED, TLSS_U_TALK:
        begin
          if (do_release)
          begin
            state_d = TLSS_U_IDLE;
            raise = cfg_batt_sup;
            ev_code_d = TLSS_EV_RELEASE_CONF;
          end
          else if (busy_tone && cfg_busy_det)
          begin
            state_d = TLSS_U_CLEARED;
            raise = 1'b1;
            ev_code_d = TLSS_EV_DISCONNECT;
          end
          else if (pol_flip && state_q == TLSS_U_SEIZED)
          begin
            state_d = TLSS_U_TALK;
            pol_d = polarity;
            raise = cfg_batt_sup;
            ev_code_d = TLSS_EV_POL_REV;
          end
          else if (pol_flip && cfg_rev_det)
          begin
            state_d = TLSS_U_CLEARED;
            pol_d = polarity;
            rev_clear_d = 1'b1;
            raise = 1'b1;
            ev_code_d = TLSS_EV_DISCONNECT;
          end
          else if (meter_rise)
          begin
            raise = 1'b1;
            ev_code_d = TLSS_EV_METER;
          end
        end
        TLSS_U_CLEARED:
        begin
          if (do_release)
          begin
            state_d = TLSS_U_IDLE;
            rev_clear_d = 1'b0;
            raise = rev_clear_q || cfg_batt_sup;
            ev_code_d = TLSS_EV_RELEASE_CONF;
          end
        end
        default:
          state_d = TLSS_U_IDLE;
      endcase
    end
  end

  assign ev_valid_d = raise || (ev_valid_q && !ev_ack);

  // State, polarity latch, message holding and line relays
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= TLSS_U_IDLE;
      pol_q <= 1'b0;
      rev_clear_q <= 1'b0;
      meter_prev_q <= 1'b0;
      ev_valid_q <= 1'b0;
      ev_code_q <= 3'h0;
      ring_q <= 1'b1;
      loop_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pol_q <= pol_d;
      rev_clear_q <= rev_clear_d;
      meter_prev_q <= meter_tone;
      ev_valid_q <= ev_valid_d;
      ev_code_q <= ev_code_d;
      ring_q <= (state_d == TLSS_U_IDLE) || (state_d == TLSS_U_RINGING);
      loop_q <= !((state_d == TLSS_U_IDLE) || (state_d == TLSS_U_RINGING));
    end
  end

  assign ring_detector_connect = ring_q;
  assign loop_close = loop_q;
  assign unit_idle = (state_q == TLSS_U_IDLE);
  assign ev_valid = ev_valid_q;
  assign ev_code = ev_code_q;

endmodule
`default_nettype wire

/* rtl/tlss_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tlss_top
  import tlss_pkg::*;
#(
  parameter bit METER_EQUIPPED = 1'b1,
  parameter int unsigned QUEUE_DEPTH = 8,
  parameter int unsigned LED_HALF_CYCLES = TLSS_LED_HALF_CYC,
  parameter logic [31:0] CARD_SERIAL = 32'h0000_0001,
  parameter logic [7:0] FIRMWARE_LEVEL = 8'h01
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] ring_sense_pin,
  input wire logic [7:0] polarity_pin,
  input wire logic [7:0] busy_tone_pin,
  input wire logic [7:0] metering_pulse_detect,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_op,
  input wire logic [2:0] cmd_unit,
  input wire logic [7:0] cmd_data,
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [2:0] msg_unit,
  output logic [2:0] msg_code,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  output logic selftest_run,
  output logic led_red,
  output logic card_enabled,
  output logic [7:0] unit_enabled,
  output logic [7:0] ring_detector_connect,
  output logic [7:0] loop_close,
  output logic [7:0] compand_alaw,
  output logic [7:0] pad_insert,
  output logic [31:0] card_serial,
  output logic [7:0] firmware_level,
  output logic metering_equipped
);

  localparam int unsigned PW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(QUEUE_DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(QUEUE_DEPTH - 1);
  localparam logic [2:0] FLASH_HALVES = 3'(2 * TLSS_LED_FLASHES);
  localparam logic [31:0] HALF_LAST = 32'(LED_HALF_CYCLES - 1);

  // First stage of the line sense pins may go metastable; only the second stage reads it
  logic [31:0] pin_meta_q, pin_sync_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_meta_q <= 32'h0;
    else
      pin_meta_q <= {metering_pulse_detect, busy_tone_pin, polarity_pin, ring_sense_pin};
  end

  // Second stage feeds the unit logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_sync_q <= 32'h0;
    else
      pin_sync_q <= pin_meta_q;
  end

  wire [7:0] ring_s = pin_sync_q[7:0];
  wire [7:0] pol_s = pin_sync_q[15:8];
  wire [7:0] busy_s = pin_sync_q[23:16];
  wire [7:0] meter_s = pin_sync_q[31:24];

  // Command decode; a unit with a message waiting holds off its seize, answer and release commands
  logic [7:0] ev_valid;
  logic [2:0] ev_code [TLSS_UNITS];
  logic [7:0] unit_idle;
  wire [7:0] sel = 8'h01 << cmd_unit;
  wire unit_op = (cmd_op == TLSS_OP_SEIZE) || (cmd_op == TLSS_OP_ANSWER) || (cmd_op == TLSS_OP_RELEASE);
  assign cmd_ready = !(unit_op && ev_valid[cmd_unit]);
  wire take = cmd_valid && cmd_ready;
  wire [7:0] do_seize = (take && cmd_op == TLSS_OP_SEIZE) ? sel : 8'h00;
  wire [7:0] do_answer = (take && cmd_op == TLSS_OP_ANSWER) ? sel : 8'h00;
  wire [7:0] do_release = (take && cmd_op == TLSS_OP_RELEASE) ? sel : 8'h00;
  wire do_cfg = take && (cmd_op == TLSS_OP_CONFIG);
  wire do_pad = take && (cmd_op == TLSS_OP_PAD);

  // Unit and card enable commands
  wire do_unit_dis = take && (cmd_op == TLSS_OP_UNIT_DIS);
  wire do_unit_en = take && (cmd_op == TLSS_OP_UNIT_EN);
  wire do_card_en = take && (cmd_op == TLSS_OP_CARD_EN);
  wire do_card_dis = take && (cmd_op == TLSS_OP_CARD_DIS);

  // Per unit settings come only from software messages
  logic [7:0] batt_q, busy_q, rev_q, alaw_q, pad_q, unit_dis_q;
  logic card_en_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      batt_q <= {8{TLSS_CFG_RESET[TLSS_CFG_BATT]}};
      busy_q <= {8{TLSS_CFG_RESET[TLSS_CFG_BUSY]}};
      rev_q <= {8{TLSS_CFG_RESET[TLSS_CFG_REV]}};
      alaw_q <= {8{TLSS_CFG_RESET[TLSS_CFG_ALAW]}};
    end
    else if (do_cfg)
    begin
      batt_q[cmd_unit] <= cmd_data[TLSS_CFG_BATT];
      busy_q[cmd_unit] <= cmd_data[TLSS_CFG_BUSY];
      rev_q[cmd_unit] <= cmd_data[TLSS_CFG_REV];
      alaw_q[cmd_unit] <= cmd_data[TLSS_CFG_ALAW];
    end
  end

  // Loss pad per call; dropped once the unit is idle so the next call starts without it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pad_q <= 8'h00;
    else if (do_pad)
      pad_q[cmd_unit] <= cmd_data[TLSS_CFG_PAD];
    else
      pad_q <= pad_q & ~unit_idle;
  end

  // Unit disable and card enable, each under its own command
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      unit_dis_q <= 8'h00;
      card_en_q <= 1'b0;
    end
    else
    begin
      if (do_unit_dis)
        unit_dis_q[cmd_unit] <= 1'b1;
      if (do_unit_en)
        unit_dis_q[cmd_unit] <= 1'b0;
      if (do_card_en)
        card_en_q <= 1'b1;
      if (do_card_dis)
        card_en_q <= 1'b0;
    end
  end

  wire [7:0] unit_on = {8{card_en_q}} & ~unit_dis_q;

  // Eight independent supervision machines
  logic [7:0] ev_ack;
  for (genvar i = 0; i < TLSS_UNITS; i++)
  begin : g_unit
    tlss_unit #(
      .METER_EQUIPPED(METER_EQUIPPED)
    ) u_unit (
      .clk(clk),
      .reset_n(reset_n),
      .unit_on(unit_on[i]),
      .ring_sense(ring_s[i]),
      .polarity(pol_s[i]),
      .busy_tone(busy_s[i]),
      .meter_tone(meter_s[i]),
      .cfg_batt_sup(batt_q[i]),
      .cfg_busy_det(busy_q[i]),
      .cfg_rev_det(rev_q[i]),
      .do_seize(do_seize[i]),
      .do_answer(do_answer[i]),
      .do_release(do_release[i]),
      .ev_ack(ev_ack[i]),
      .ring_detector_connect(ring_detector_connect[i]),
      .loop_close(loop_close[i]),
      .unit_idle(unit_idle[i]),
      .ev_valid(ev_valid[i]),
      .ev_code(ev_code[i])
    );
  end

  // Lowest numbered waiting unit goes into the queue first
  logic [PW:0] count_q;
  logic [PW-1:0] wr_q, rd_q;
  logic [2:0] q_unit_q [QUEUE_DEPTH];
  logic [2:0] q_code_q [QUEUE_DEPTH];
  logic [2:0] grant_idx;
  logic grant_any;
  always_comb
  begin
    grant_idx = 3'h0;
    grant_any = 1'b0;
    for (int k = TLSS_UNITS - 1; k >= 0; k--)
    begin
      if (ev_valid[k])
      begin
        grant_idx = 3'(k);
        grant_any = 1'b1;
      end
    end
  end

  wire q_full = (count_q == DEPTH_CNT);
  wire push = grant_any && !q_full;
  wire pop = msg_valid && msg_ready;
  assign ev_ack = push ? (8'h01 << grant_idx) : 8'h00;

  // Next slot, wrapping at the last one so any depth works
  wire [PW-1:0] wr_next = (wr_q == LAST_SLOT) ? '0 : wr_q + 1'b1;
  wire [PW-1:0] rd_next = (rd_q == LAST_SLOT) ? '0 : rd_q + 1'b1;

  // Message queue storage in flops, written in event order
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < QUEUE_DEPTH; k++)
      begin
        q_unit_q[k] <= 3'h0;
        q_code_q[k] <= 3'h0;
      end
    end
    else if (push)
    begin
      q_unit_q[wr_q] <= grant_idx;
      q_code_q[wr_q] <= ev_code[grant_idx];
    end
  end

  // Write and read pointers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_next;
      if (pop)
        rd_q <= rd_next;
    end
  end

  // Entry count; a push and a pop together leave it unchanged
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_q <= '0;
    else if (push && !pop)
      count_q <= count_q + 1'b1;
    else if (pop && !push)
      count_q <= count_q - 1'b1;
  end

  assign msg_valid = (count_q != '0);
  assign msg_unit = q_unit_q[rd_q];
  assign msg_code = q_code_q[rd_q];

  // Faceplate indicator: test, three flashes, lit until card enabled
  tlss_led_state_t led_q, led_d;
  logic [31:0] half_cnt_q;
  logic [2:0] halves_q;
  logic led_on_q;
  wire half_end = (half_cnt_q == HALF_LAST);
  wire in_flash = (led_q == TLSS_L_FLASH);
  wire last_half = half_end && (halves_q == FLASH_HALVES - 3'h1);

  always_comb
  begin
    led_d = led_q;
    case (led_q)
      TLSS_L_TEST:
      begin
        if (selftest_done)
          led_d = selftest_pass ? TLSS_L_FLASH : TLSS_L_FAIL;
      end
      TLSS_L_FLASH:
      begin
        if (last_half)
          led_d = TLSS_L_HOLD;
      end
      TLSS_L_HOLD:
      begin
        if (card_en_q)
          led_d = TLSS_L_OFF;
      end
      TLSS_L_OFF:
      begin
        if (!card_en_q)
          led_d = TLSS_L_HOLD;
      end
      TLSS_L_FAIL:
        led_d = TLSS_L_FAIL;
      default:
        led_d = TLSS_L_TEST;
    endcase
  end

  // Indicator state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      led_q <= TLSS_L_TEST;
    else
      led_q <= led_d;
  end

  // Cycles within one flash half
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      half_cnt_q <= 32'h0;
    else if (in_flash && !half_end)
      half_cnt_q <= half_cnt_q + 32'h1;
    else
      half_cnt_q <= 32'h0;
  end

  // Flash halves completed, cleared outside the flash phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      halves_q <= 3'h0;
    else if (in_flash && half_end)
      halves_q <= halves_q + 3'h1;
    else if (!in_flash)
      halves_q <= 3'h0;
  end

  // Even halves dark, odd halves lit, so each flash is a gap then a glow; outside the flash, dark only on an enabled card
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      led_on_q <= 1'b1;
    else if (led_d == TLSS_L_FLASH)
      led_on_q <= in_flash ? (half_end ? !halves_q[0] : led_on_q) : 1'b0;
    else
      led_on_q <= (led_d != TLSS_L_OFF);
  end

  assign led_red = led_on_q;
  assign selftest_run = (led_q == TLSS_L_TEST);

  // Card and unit status
  assign card_enabled = card_en_q;
  assign unit_enabled = unit_on;
  assign compand_alaw = alaw_q;
  assign pad_insert = pad_q;

  // Identification, fixed per build
  assign card_serial = CARD_SERIAL;
  assign firmware_level = FIRMWARE_LEVEL;
  assign metering_equipped = METER_EQUIPPED;

endmodule
`default_nettype wire

/* bench/tlss_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module tlss_top_props
  import tlss_pkg::*;
#(
  parameter bit METER_EQUIPPED = 1'b1,
  parameter logic [31:0] CARD_SERIAL = 32'h0000_0001,
  parameter logic [7:0] FIRMWARE_LEVEL = 8'h01
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic [2:0] msg_unit,
  input wire logic [2:0] msg_code,
  input wire logic selftest_run,
  input wire logic selftest_pass,
  input wire logic led_red,
  input wire logic card_enabled,
  input wire logic [7:0] unit_enabled,
  input wire logic [7:0] ring_detector_connect,
  input wire logic [7:0] loop_close,
  input wire logic [31:0] card_serial,
  input wire logic [7:0] firmware_level,
  input wire logic metering_equipped
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Line relays, message port, indicator and identity
  chk_relay_pair: assert property (ring_detector_connect == ~loop_close)
    else $error("detector and loop relays not opposite");
  chk_disabled_open: assert property ((~unit_enabled & ~$past(unit_enabled) & ~$past(unit_enabled, 3) & loop_close) == 8'h00)
    else $error("disabled unit holds its loop");
  chk_card_gate: assert property (!card_enabled |-> unit_enabled == 8'h00)
    else $error("unit enabled on disabled card");
  chk_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_unit) && $stable(msg_code))
    else $error("queue head changed before pop");
  chk_code_legal: assert property (msg_valid |-> msg_code != 3'h0 && msg_code != 3'h7)
    else $error("undefined message code");
  chk_meter_variant: assert property (metering_equipped == METER_EQUIPPED && !(msg_valid && !METER_EQUIPPED && msg_code == TLSS_EV_METER))
    else $error("metering report on wrong variant");
  chk_test_lit: assert property (selftest_run |-> led_red)
    else $error("indicator dark during self-test");
  chk_enabled_dark: assert property (card_enabled && $past(card_enabled) && $past(card_enabled, 3) && selftest_pass && !selftest_run |-> !led_red)
    else $error("indicator lit on enabled card");
  chk_identity_fixed: assert property (card_serial == CARD_SERIAL && firmware_level == FIRMWARE_LEVEL)
    else $error("identification data wrong");

  // Main scenarios reached
  cover property (msg_valid && msg_ready);
  cover property ($rose(|loop_close));
  cover property ($fell(led_red));
endmodule

bind tlss_top tlss_top_props #(.METER_EQUIPPED(METER_EQUIPPED), .CARD_SERIAL(CARD_SERIAL),
  .FIRMWARE_LEVEL(FIRMWARE_LEVEL)) u_props (.clk(clk), .reset_n(reset_n), .msg_valid(msg_valid),
  .msg_ready(msg_ready), .msg_unit(msg_unit), .msg_code(msg_code), .selftest_run(selftest_run),
  .selftest_pass(selftest_pass), .led_red(led_red), .card_enabled(card_enabled),
  .unit_enabled(unit_enabled), .ring_detector_connect(ring_detector_connect), .loop_close(loop_close),
  .card_serial(card_serial), .firmware_level(firmware_level), .metering_equipped(metering_equipped));
`default_nettype wire

/* bench/tlss_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tlss_line_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] loop_close,
  output logic [7:0] ring_sense_pin,
  output logic [7:0] polarity_pin,
  output logic [7:0] busy_tone_pin,
  output logic [7:0] metering_pulse_detect
);
  logic [7:0] ring_req = 8'h00;
  logic [7:0] busy_req = 8'h00;

  initial
  begin
    polarity_pin = 8'h00;
    metering_pulse_detect = 8'h00;
  end

  // Ringing stops when the loop closes, busy tone stops when it opens
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ring_sense_pin <= 8'h00;
      busy_tone_pin <= 8'h00;
    end
    else
    begin
      ring_sense_pin <= (ring_sense_pin | ring_req) & ~loop_close;
      busy_tone_pin <= (busy_tone_pin | busy_req) & loop_close;
    end
  end

  // Start ringing (tone=0) or busy tone (tone=1) on one unit
  task automatic raise(input int u, input bit tone);
    @(posedge clk);
    if (tone)
      busy_req[u] <= 1'b1;
    else
      ring_req[u] <= 1'b1;
    @(posedge clk);
    ring_req <= 8'h00;
    busy_req <= 8'h00;
  endtask

  // Battery reversal at far-end answer or clear
  task automatic flip(input int u);
    @(posedge clk);
    polarity_pin[u] <= ~polarity_pin[u];
  endtask

  // One metering burst of four cycles
  task automatic meter(input int u);
    @(posedge clk);
    metering_pulse_detect[u] <= 1'b1;
    repeat (4) @(posedge clk);
    metering_pulse_detect[u] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/test_trunk_loop_start_supervisor.sv */
`timescale 1ns/10ps
`default_nettype none
module test_trunk_loop_start_supervisor;
  import tlss_pkg::*;
  localparam logic [31:0] SERIAL = 32'h0000_5a5a; // Arbitrary value
  localparam logic [7:0] FW = 8'h2c; // Arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [2:0] cmd_unit = 3'h0;
  logic [7:0] cmd_data = 8'h00;
  logic msg_ready = 1'b0;
  logic st_done = 1'b0;
  logic st_pass = 1'b0;
  logic cmd_ready, msg_valid, st_run, led_red, card_en, meq;
  logic [2:0] msg_unit, msg_code;
  logic [7:0] ring_pin, pol_pin, busy_pin, meter_pin, unit_en, rdc, loop, alaw, pad, fw;
  logic [31:0] serial;
  logic [7:0] cfg [8];
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  tlss_top #(.LED_HALF_CYCLES(4), .CARD_SERIAL(SERIAL), .FIRMWARE_LEVEL(FW)) dut (.clk(clk),
    .reset_n(reset_n), .ring_sense_pin(ring_pin), .polarity_pin(pol_pin), .busy_tone_pin(busy_pin),
    .metering_pulse_detect(meter_pin), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_unit(cmd_unit), .cmd_data(cmd_data), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_unit(msg_unit), .msg_code(msg_code), .selftest_done(st_done), .selftest_pass(st_pass),
    .selftest_run(st_run), .led_red(led_red), .card_enabled(card_en), .unit_enabled(unit_en),
    .ring_detector_connect(rdc), .loop_close(loop), .compand_alaw(alaw), .pad_insert(pad),
    .card_serial(serial), .firmware_level(fw), .metering_equipped(meq));

  tlss_line_model line (.clk(clk), .reset_n(reset_n), .loop_close(loop), .ring_sense_pin(ring_pin),
    .polarity_pin(pol_pin), .busy_tone_pin(busy_pin), .metering_pulse_detect(meter_pin));

  // Cut a hung run short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches = mismatches + 1;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Hold a command until it is taken
  task automatic cmd(input logic [3:0] op, input logic [2:0] u, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_unit <= u;
    cmd_data <= d;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (cmd_ready === 1'b1)
        break;
    end
    cmd_valid <= 1'b0;
    chk(cmd_ready, 1'b1);
  endtask

  // Expect one message, or silence when none is due
  task automatic opt_msg(input logic on, input int u, input logic [2:0] code);
    if (!on)
    begin
      wait_n(14);
      chk(msg_valid, 1'b0);
      return;
    end
    for (int i = 0; i < 60 && msg_valid !== 1'b1; i++)
      wait_n(1);
    chk({msg_valid, msg_unit, msg_code}, {1'b1, u[2:0], code});
    @(posedge clk);
    msg_ready <= 1'b1;
    @(posedge clk);
    msg_ready <= 1'b0;
  endtask

  // Release confirm is due with battery supervision or after a reversal clear
  function automatic logic rel_due(input logic [7:0] c, input logic rev_cleared);
    return c[TLSS_CFG_BATT] | rev_cleared;
  endfunction

  // Main sequence
  initial
  begin
    int falls;
    int darks;
    logic [7:0] c;
    logic [7:0] a;
    void'($urandom(79265));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wait_n(3);
    chk({st_run, led_red, card_en, alaw, pad, loop, rdc}, {3'b110, 24'h0, 8'hff});
    chk({serial, fw, meq}, {SERIAL, FW, 1'b1});
    @(posedge clk);
    st_done <= 1'b1;
    st_pass <= 1'b1;
    falls = 0;
    darks = 0;
    for (int i = 0; i < 60; i++)
    begin
      c[0] = led_red;
      wait_n(1);
      falls += int'(c[0] && !led_red);
      darks += int'(!led_red);
    end
    // One dark half of four cycles per flash
    chk({falls[7:0], darks[7:0], led_red}, {8'(TLSS_LED_FLASHES), 8'(TLSS_LED_FLASHES * 4), 1'b1});
    cmd(TLSS_OP_CARD_EN, 3'h0, 8'h00);
    wait_n(4);
    chk({card_en, unit_en, led_red}, {1'b1, 8'hff, 1'b0});
    $display("test selftest done");
    for (int u = 0; u < 8; u++)
    begin
      cfg[u] = (u == 0) ? 8'h0f : (u == 1) ? 8'h00 : 8'($urandom & 32'hf);
      a[u] = cfg[u][TLSS_CFG_ALAW];
      cmd(TLSS_OP_CONFIG, 3'(u), cfg[u]);
    end
    wait_n(2);
    chk(alaw, a);
    $display("test config done");
    for (int u = 0; u < 8; u++)
    begin
      c = cfg[u];
      cmd(TLSS_OP_SEIZE, 3'(u), 8'h00);
      wait_n(3);
      chk({rdc[u], loop[u]}, 2'b01);
      opt_msg(c[0], u, TLSS_EV_SEIZE_ACK);
      cmd(TLSS_OP_PAD, 3'(u), 8'h01);
      wait_n(2);
      chk(pad[u], 1'b1);
      line.flip(u);
      opt_msg(c[0], u, TLSS_EV_POL_REV);
      line.meter(u);
      opt_msg(1'b1, u, TLSS_EV_METER);
      line.raise(u, 1'b1);
      opt_msg(c[1], u, TLSS_EV_DISCONNECT);
      cmd(TLSS_OP_RELEASE, 3'(u), 8'h00);
      opt_msg(c[0], u, TLSS_EV_RELEASE_CONF);
      chk({rdc[u], loop[u], pad[u]}, 3'b100);
    end
    $display("test outgoing done");
    for (int u = 0; u < 8; u++)
    begin
      c = cfg[u];
      line.raise(u, 1'b0);
      wait_n(6);
      chk({rdc[u], loop[u]}, 2'b10);
      cmd(TLSS_OP_ANSWER, 3'(u), 8'h00);
      wait_n(3);
      chk({rdc[u], loop[u]}, 2'b01);
      opt_msg(c[0], u, TLSS_EV_ANSWER_ACK);
      line.flip(u);
      opt_msg(c[2], u, TLSS_EV_DISCONNECT);
      cmd(TLSS_OP_RELEASE, 3'(u), 8'h00);
      opt_msg(rel_due(c, c[2]), u, TLSS_EV_RELEASE_CONF);
    end
    $display("test incoming done");
    cmd(TLSS_OP_UNIT_DIS, 3'h3, 8'h00);
    cmd(TLSS_OP_SEIZE, 3'h3, 8'h00);
    wait_n(4);
    chk({unit_en, loop[3]}, {8'hf7, 1'b0});
    cmd(TLSS_OP_UNIT_EN, 3'h3, 8'h00);
    cmd(TLSS_OP_SEIZE, 3'h3, 8'h00);
    wait_n(3);
    chk(loop[3], 1'b1);
    opt_msg(cfg[3][0], 3, TLSS_EV_SEIZE_ACK);
    cmd(TLSS_OP_CARD_DIS, 3'h0, 8'h00);
    wait_n(6);
    chk({card_en, unit_en, loop, led_red}, {1'b0, 16'h0, 1'b1});
    $display("test disable done");
    results();
  end
endmodule
`default_nettype wire
